/* File: design/ras_stack.sv */
/*
  return address stack of the core: 31 x 21 bit storage, pointer, flags,
  top entry access, fast shadow and program counter sequencing.
  assumes the sequencer gives at most one command per cycle, synchronous to
  i_mclk, and that a power-on reset is signalled by i_por apart from i_resetn.
*/
// Behaviour
// - 21-bit pc; fetches past implemented memory return zeros, a no-operation
// - reset starts at 000000h; interrupts vector to 000008h or 000018h
// - calls and interrupt acknowledge push the program counter
// - return, return with literal, return from interrupt pop into pc
// - call and return leave the pc latch registers untouched
// - 31 entries of 21 bits, 5-bit pointer cleared by every reset
// - pointer zero has no entry; it is only the empty state
// - push increments pointer then writes next-instruction pc
// - pop copies addressed entry to pc then decrements pointer
// - three top entry registers read and overwrite the addressed entry
// - software reads and writes the pointer directly
// - full flag sets after 31 pushes without pop
// - with reset option, 31st push stores next-instruction pc plus two, flags, resets
// - without option, 31st push sets full, pointer 31, later pushes ignored
// - pop at zero loads zero, sets underflow, pointer stays zero
// - full or underflow sets flag then resets device if option enabled
// - full and underflow flags cleared only by software, power-on or i_resetn
// - pointer register: bit7 full, bit6 underflow, bit5 zero, bits4-0 pointer
// - explicit push stores next-instruction pc without changing flow
// - explicit pop discards top without changing pc
// - interrupt vectoring loads the one-deep shadow; no software access
// - fast call saves shadow; fast return restores from it
`timescale 1ns/1ps
`include "ras_regs.svh"
module ras_stack #(
  parameter int DEPTH = 31,
  parameter logic [20:0] MEM_END = 21'h004000
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_por,
  input wire ras_pkg::ras_cmd_s i_cmd,
  input wire ras_pkg::ras_addr_t i_pc_next,
  input wire ras_pkg::ras_addr_t i_target,
  input wire ras_pkg::ras_shadow_s i_regs,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire ras_pkg::ras_addr_t i_fetch_addr,
  input wire logic [15:0] i_fetch_word,
  output logic [7:0] o_rdata,
  output ras_pkg::ras_addr_t o_pc,
  output logic o_pc_load,
  output ras_pkg::ras_shadow_s o_regs,
  output logic o_regs_load,
  output logic o_dev_reset,
  output logic [15:0] o_fetch_word
);
  typedef struct packed {
    ras_pkg::ras_state_e st;
    logic [4:0] ptr;
    logic full;
    logic under;
    logic ovr_en;
    ras_pkg::ras_shadow_s shadow;
    logic [7:0] rdata;
    ras_pkg::ras_addr_t pc;
    logic pc_load;
    ras_pkg::ras_shadow_s regs;
    logic regs_load;
    logic dev_reset;
    logic [15:0] fetch_word;
  } ras_state_s;

  ras_pkg::ras_addr_t mem [1:DEPTH];
  ras_state_s r;
  ras_state_s next_r;
  logic mem_we;
  logic [4:0] mem_idx;
  ras_pkg::ras_addr_t mem_wd;
  ras_pkg::ras_addr_t top;
  logic do_push;
  logic do_pop;

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  function automatic logic is_top(input logic [3:0] a);
    is_top = (a >= `RAS_OFF_TOP_LOW) && (a <= `RAS_OFF_TOP_UPPER);
  endfunction : is_top

  assign top = (r.ptr == 5'h00) ? 21'h000000 : mem[r.ptr];
  assign do_push = i_cmd.call | i_cmd.irq_ack | i_cmd.push;
  assign do_pop = i_cmd.ret | i_cmd.pop;

  always_comb
  begin
    next_r = r;
    mem_we = 1'b0;
    mem_idx = r.ptr;
    mem_wd = i_pc_next;
    next_r.pc_load = 1'b0;
    next_r.regs_load = 1'b0;
    next_r.dev_reset = 1'b0;
    next_r.rdata = 8'h00;
    // past implemented memory a fetch reads as zero
    next_r.fetch_word = (i_fetch_addr >= MEM_END) ? 16'h0000 : i_fetch_word;
    case (r.st)
      ras_pkg::RAS_ST_RESET:
      begin
        // device reset in progress: pointer returns to zero, flags kept
        next_r.ptr = `RAS_PTR_RESET;
        next_r.pc = `RAS_RESET_VECTOR;
        next_r.pc_load = 1'b1;
        next_r.st = ras_pkg::RAS_ST_RUN;
      end
      ras_pkg::RAS_ST_HOLD:
        next_r.st = ras_pkg::RAS_ST_RUN;
      ras_pkg::RAS_ST_RUN:
      begin
        if (i_rd)
        begin
          if (is_reg(i_addr, `RAS_OFF_PTR))
            next_r.rdata = {r.full, r.under, 1'b0, r.ptr};
          else if (is_reg(i_addr, `RAS_OFF_TOP_LOW))
            next_r.rdata = top[7:0];
          else if (is_reg(i_addr, `RAS_OFF_TOP_HIGH))
            next_r.rdata = top[15:8];
          else if (is_reg(i_addr, `RAS_OFF_TOP_UPPER))
            next_r.rdata = {3'h0, top[20:16]};
          else if (is_reg(i_addr, `RAS_OFF_CONFIG))
            next_r.rdata = {7'h00, r.ovr_en};
          else
            next_r.rdata = 8'h00;
        end
        if (do_push)
        begin
          if (i_cmd.irq_ack)
          begin
            next_r.shadow = i_regs;
            next_r.pc = i_cmd.irq_high ? `RAS_HIGH_VECTOR : `RAS_LOW_VECTOR;
            next_r.pc_load = 1'b1;
          end
          else if (i_cmd.call)
          begin
            if (i_cmd.call_fast)
              next_r.shadow = i_regs;
            next_r.pc = i_target;
            next_r.pc_load = 1'b1;
          end
          if (r.ptr == 5'(DEPTH - 1))
          begin
            next_r.full = 1'b1;
            mem_we = 1'b1;
            mem_idx = 5'(DEPTH);
            if (r.ovr_en)
            begin
              mem_wd = 21'(i_pc_next + `RAS_PC_STEP);
              next_r.ptr = `RAS_PTR_RESET;
              next_r.dev_reset = 1'b1;
              next_r.st = ras_pkg::RAS_ST_RESET;
            end
            else
              next_r.ptr = 5'(DEPTH);
          end
          else if (r.ptr == 5'(DEPTH))
            next_r.full = 1'b1;
          else
          begin
            mem_we = 1'b1;
            mem_idx = 5'(r.ptr + 5'h01);
            next_r.ptr = 5'(r.ptr + 5'h01);
          end
        end
        else if (do_pop)
        begin
          if (i_cmd.ret)
          begin
            next_r.pc = top;
            next_r.pc_load = 1'b1;
            if (i_cmd.ret_fast)
            begin
              next_r.regs = r.shadow;
              next_r.regs_load = 1'b1;
            end
          end
          if (r.ptr == 5'h00)
          begin
            next_r.under = 1'b1;
            if (r.ovr_en)
            begin
              next_r.dev_reset = 1'b1;
              next_r.st = ras_pkg::RAS_ST_RESET;
            end
          end
          else
            next_r.ptr = 5'(r.ptr - 5'h01);
        end
        if (i_wr)
        begin
          if (is_reg(i_addr, `RAS_OFF_PTR))
          begin
            next_r.ptr = i_wdata[`RAS_PTR_MSB:0];
            // clear-only flags; a hardware set in the same cycle wins
            if (!i_wdata[`RAS_BIT_FULL] && !next_r.full)
              next_r.full = 1'b0;
            else if (!i_wdata[`RAS_BIT_FULL] && !(do_push && r.ptr >= 5'(DEPTH - 1)))
              next_r.full = 1'b0;
            if (!i_wdata[`RAS_BIT_UNDER] && !(do_pop && r.ptr == 5'h00))
              next_r.under = 1'b0;
          end
          else if (r.ptr != 5'h00 && is_top(i_addr))
          begin
            mem_we = 1'b1;
            mem_idx = r.ptr;
            mem_wd = top;
            if (is_reg(i_addr, `RAS_OFF_TOP_LOW))
              mem_wd[7:0] = i_wdata;
            else if (is_reg(i_addr, `RAS_OFF_TOP_HIGH))
              mem_wd[15:8] = i_wdata;
            else
              mem_wd[20:16] = i_wdata[4:0];
          end
          else if (is_reg(i_addr, `RAS_OFF_CONFIG))
            next_r.ovr_en = i_wdata[0];
        end
      end
      default:
        next_r.st = ras_pkg::RAS_ST_RUN;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      r <= '0;
      r.st <= ras_pkg::RAS_ST_HOLD;
      r.ptr <= `RAS_PTR_RESET;
      r.ovr_en <= 1'b1;
    end
    else
    begin
      r <= next_r;
      if (i_por)
      begin
        r.full <= 1'b0;
        r.under <= 1'b0;
        r.ptr <= `RAS_PTR_RESET;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (mem_we && mem_idx != 5'h00)
      mem[mem_idx] <= mem_wd;
  end

  assign o_rdata = r.rdata;
  assign o_pc = r.pc;
  assign o_pc_load = r.pc_load;
  assign o_regs = r.regs;
  assign o_regs_load = r.regs_load;
  assign o_dev_reset = r.dev_reset;
  assign o_fetch_word = r.fetch_word;

  AST_PUSH_INC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_push && !i_wr && !i_por && r.ptr < 5'(DEPTH - 1))
    |=> (r.ptr == $past(r.ptr) + 5'h01))
    else $error("push did not advance pointer");
  AST_POP_DEC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_pop && !do_push && !i_wr && !i_por && r.ptr != 5'h00)
    |=> (r.ptr == $past(r.ptr) - 5'h01))
    else $error("pop did not lower pointer");
  AST_RET_PC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_cmd.ret && !do_push) |=> (o_pc_load && o_pc == $past(top)))
    else $error("return did not load top entry");
  AST_UNDER: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_pop && !do_push && r.ptr == 5'h00 && !i_wr && !i_por)
    |=> (r.under && r.ptr == 5'h00))
    else $error("underflow not flagged");
  AST_FULL_HOLD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_push && r.ptr == 5'(DEPTH) && !i_wr && !i_por)
    |=> (r.ptr == 5'(DEPTH) && r.full))
    else $error("push past full moved pointer");
  AST_OVR_RESET: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_push && r.ptr == 5'(DEPTH - 1) && r.ovr_en && !i_wr
    && !i_por)
    |=> o_dev_reset ##1 (o_pc_load && o_pc == `RAS_RESET_VECTOR && r.full))
    else $error("overflow reset sequence wrong");
  AST_IRQ_VEC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_cmd.irq_ack)
    |=> (o_pc == ($past(i_cmd.irq_high) ? `RAS_HIGH_VECTOR : `RAS_LOW_VECTOR)))
    else $error("interrupt vector wrong");
  AST_FAST_RET: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && (i_cmd.irq_ack || (i_cmd.call && i_cmd.call_fast)))
    ##1 !(i_cmd.irq_ack || i_cmd.call_fast)
    ##1 (r.st == ras_pkg::RAS_ST_RUN && i_cmd.ret && i_cmd.ret_fast && !do_push)
    |=> (o_regs_load && o_regs == $past(i_regs, 3)))
    else $error("fast return restored wrong values");
  AST_PTR_READ: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_rd && i_addr == `RAS_OFF_PTR)
    |=> (o_rdata == {$past(r.full), $past(r.under), 1'b0, $past(r.ptr)}))
    else $error("pointer register read wrong");
  AST_FETCH_ZERO: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_fetch_addr >= MEM_END) |=> (o_fetch_word == 16'h0000))
    else $error("fetch past memory not zero");
  AST_PUSH_STORE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_push && !i_wr && !i_por
    && r.ptr < 5'(DEPTH - 1))
    |=> (top == $past(i_pc_next)))
    else $error("push stored wrong value");
  AST_FULL_SET: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_push && !i_por
    && r.ptr == 5'(DEPTH - 1))
    |=> r.full)
    else $error("full flag not set on last push");
  AST_UNDER_RST: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_pop && !do_push && r.ptr == 5'h00
    && r.ovr_en && !i_wr && !i_por)
    |=> (o_dev_reset && r.under))
    else $error("underflow reset not requested");
  AST_NO_OPT_RST: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (!r.ovr_en)
    |=> (!o_dev_reset))
    else $error("device reset without option");
  AST_RST_VEC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_dev_reset
    |=> (o_pc_load && o_pc == `RAS_RESET_VECTOR && r.ptr == `RAS_PTR_RESET))
    else $error("device reset did not restart at reset vector");
  AST_FULL_KEEP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.full && !i_por && !(r.st == ras_pkg::RAS_ST_RUN && i_wr
    && i_addr == `RAS_OFF_PTR && !i_wdata[`RAS_BIT_FULL]))
    |=> r.full)
    else $error("full flag lost without clear");
  AST_UNDER_KEEP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.under && !i_por && !(r.st == ras_pkg::RAS_ST_RUN && i_wr
    && i_addr == `RAS_OFF_PTR && !i_wdata[`RAS_BIT_UNDER]))
    |=> r.under)
    else $error("underflow flag lost without clear");
  AST_PTR_WRITE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_wr && i_addr == `RAS_OFF_PTR && !i_por)
    |=> (r.ptr == $past(i_wdata[`RAS_PTR_MSB:0])))
    else $error("pointer write not taken");
  AST_TOP_ZERO: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_rd && is_top(i_addr) && r.ptr == 5'h00)
    |=> (o_rdata == 8'h00))
    else $error("top entry read at empty pointer not zero");
  AST_POP_NO_PC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_cmd.pop && !i_cmd.ret && !do_push)
    |=> (!o_pc_load))
    else $error("explicit pop changed the pc");
  AST_SHADOW_IRQ: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_cmd.irq_ack)
    |=> (r.shadow == $past(i_regs)))
    else $error("interrupt did not load shadow");
  AST_PUSH_NO_PC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && i_cmd.push && !i_cmd.call && !i_cmd.irq_ack)
    |=> (!o_pc_load))
    else $error("explicit push changed the pc");
  AST_OVR_STORE: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (r.st == ras_pkg::RAS_ST_RUN && do_push && r.ptr == 5'(DEPTH - 1) && r.ovr_en
    && !i_wr)
    |=> (mem[DEPTH] == 21'($past(i_pc_next) + `RAS_PC_STEP)))
    else $error("overflow push stored wrong value");

  COV_CALL_RET: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    i_cmd.call ##[1:20] i_cmd.ret);
  COV_FULL: cover property (@(posedge i_mclk) disable iff (!i_resetn) $rose(r.full));
  COV_UNDER: cover property (@(posedge i_mclk) disable iff (!i_resetn) $rose(r.under));
  COV_DEVRST: cover property (@(posedge i_mclk) disable iff (!i_resetn) o_dev_reset);
  COV_FAST_RET: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    i_cmd.call_fast ##2 (i_cmd.ret && i_cmd.ret_fast));
endmodule : ras_stack

/* File: include/ras_pkg.sv */
/*
  types shared by the return address stack; assumes nothing beyond a
  SystemVerilog compiler
*/
package ras_pkg;
  typedef logic [20:0] ras_addr_t;
  typedef struct packed {
    logic call;
    logic call_fast;
    logic irq_ack;
    logic irq_high;
    logic ret;
    logic ret_fast;
    logic push;
    logic pop;
  } ras_cmd_s;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [7:0] bank;
  } ras_shadow_s;
  typedef enum logic [2:0] {
    RAS_ST_RUN = 3'b001,
    RAS_ST_RESET = 3'b010,
    RAS_ST_HOLD = 3'b100
  } ras_state_e;
endpackage : ras_pkg

/* File: include/ras_regs.svh */
/*
  register offsets, field positions, reset values and fixed addresses of the
  return address stack; assumes inclusion by bare name from the design
*/
`ifndef RAS_REGS_SVH
`define RAS_REGS_SVH
`define RAS_OFF_PTR 4'h0
`define RAS_OFF_TOP_LOW 4'h1
`define RAS_OFF_TOP_HIGH 4'h2
`define RAS_OFF_TOP_UPPER 4'h3
`define RAS_OFF_CONFIG 4'h4
`define RAS_BIT_FULL 7
`define RAS_BIT_UNDER 6
`define RAS_PTR_MSB 4
`define RAS_RESET_VECTOR 21'h000000
`define RAS_HIGH_VECTOR 21'h000008
`define RAS_LOW_VECTOR 21'h000018
`define RAS_PTR_RESET 5'h00
`define RAS_CONFIG_RESET 8'h01
`define RAS_PC_STEP 21'h000002
`endif

/* File: verification/ras_core_model.sv */
/*
  instruction sequencer model facing the return address stack: turns a bench
  request code into one command pulse, tracks the pc it is handed back.
  assumes requests change right after a rising edge of i_mclk.
*/
`timescale 1ns/1ps
module ras_core_model (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [3:0] i_req,
  input wire ras_pkg::ras_addr_t i_dest,
  input wire ras_pkg::ras_addr_t i_pc,
  input wire logic i_pc_load,
  output ras_pkg::ras_cmd_s o_cmd,
  output ras_pkg::ras_addr_t o_pc_next,
  output ras_pkg::ras_addr_t o_target
);
  ras_pkg::ras_addr_t pc;
  // execution starts at the reset vector, then follows every pc load
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      pc <= 21'h000000;
    else if (i_pc_load)
      pc <= i_pc;
  end
  assign o_pc_next = pc + 21'h000002;
  // destination is only meaningful on a call, otherwise scrambled
  assign o_target = o_cmd.call ? i_dest : ~i_dest;
  always_comb
  begin
    o_cmd = '0;
    o_cmd.call = (i_req == 4'h1) || (i_req == 4'h2);
    o_cmd.call_fast = (i_req == 4'h2);
    o_cmd.irq_ack = (i_req == 4'h3) || (i_req == 4'h4);
    o_cmd.irq_high = (i_req == 4'h4);
    o_cmd.ret = (i_req == 4'h5) || (i_req == 4'h6);
    o_cmd.ret_fast = (i_req == 4'h6);
    o_cmd.push = (i_req == 4'h7);
    o_cmd.pop = (i_req == 4'h8);
  end
endmodule : ras_core_model

/* File: verification/ras_stack_test.sv */
/*
  self-checking bench of the return address stack with the sequencer model.
  assumes the design answers one cycle after each request, as handed over.
*/
`timescale 1ns/1ps
module ras_stack_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic por = 1'b0;
  logic [3:0] req = 4'h0;
  ras_pkg::ras_addr_t dest = 21'h000000;
  ras_pkg::ras_shadow_s regs_v = 24'h000000;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  ras_pkg::ras_addr_t fetch_addr = 21'h000000;
  logic [15:0] fetch_word = 16'h0000;
  ras_pkg::ras_cmd_s cmd;
  ras_pkg::ras_addr_t pc_next, target, pc;
  ras_pkg::ras_shadow_s regs_out;
  logic [7:0] rdata, d;
  logic pc_load, regs_load, dev_reset;
  logic [15:0] fword;
  int error_cnt = 0;
  int check_count = 0;
  always #25 mclk = ~mclk;
  ras_core_model ras_core_model_inst (.i_mclk(mclk), .i_resetn(resetn), .i_req(req),
    .i_dest(dest), .i_pc(pc), .i_pc_load(pc_load), .o_cmd(cmd), .o_pc_next(pc_next),
    .o_target(target));
  ras_stack ras_stack_inst (.i_mclk(mclk), .i_resetn(resetn), .i_por(por), .i_cmd(cmd),
    .i_pc_next(pc_next), .i_target(target), .i_regs(regs_v), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_fetch_addr(fetch_addr),
    .i_fetch_word(fetch_word), .o_rdata(rdata), .o_pc(pc), .o_pc_load(pc_load),
    .o_regs(regs_out), .o_regs_load(regs_load), .o_dev_reset(dev_reset),
    .o_fetch_word(fword));
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    rd_reg(a, d);
    check(name, {16'h0000, d}, {16'h0000, exp});
  endtask : rd_chk
  // one command pulse with register values; returns just after the edge that takes it
  task automatic op_r(input logic [3:0] k, input ras_pkg::ras_addr_t t,
    input ras_pkg::ras_shadow_s s);
    @(posedge mclk);
    req <= k;
    dest <= t;
    regs_v <= s;
    @(posedge mclk);
    req <= 4'h0;
    #1;
  endtask : op_r
  task automatic op(input logic [3:0] k, input ras_pkg::ras_addr_t t);
    op_r(k, t, regs_v);
  endtask : op
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_chk("ptr_reset", 4'h0, 8'h00);
    rd_chk("cfg_reset", 4'h4, 8'h01);
    rd_chk("top_at_zero", 4'h1, 8'h00);
    wr_reg(4'h4, 8'h00);
    op(4'h1, 21'h000100);
    check("call_load", {23'h0, pc_load}, 24'h000001);
    check("call_pc", {3'h0, pc}, 24'h000100);
    rd_chk("ptr_push", 4'h0, 8'h01);
    rd_chk("top_low", 4'h1, 8'h02);
    rd_chk("top_high", 4'h2, 8'h00);
    rd_chk("top_upper", 4'h3, 8'h00);
    wr_reg(4'h1, 8'h44);
    op(4'h5, 21'h000000);
    check("ret_pc", {3'h0, pc}, 24'h000044);
    rd_chk("ptr_pop", 4'h0, 8'h00);
    wr_reg(4'h1, 8'h99);
    op(4'h5, 21'h000000);
    check("under_load", {23'h0, pc_load}, 24'h000001);
    check("under_pc", {3'h0, pc}, 24'h000000);
    check("under_noreset", {23'h0, dev_reset}, 24'h000000);
    rd_chk("under_flag", 4'h0, 8'h40);
    wr_reg(4'h0, 8'h00);
    rd_chk("flag_clear", 4'h0, 8'h00);
    wr_reg(4'h0, 8'h01);
    rd_chk("top_zero_wr", 4'h1, 8'h44);
    wr_reg(4'h0, 8'h05);
    rd_chk("ptr_write", 4'h0, 8'h05);
    wr_reg(4'h0, 8'h00);
    op(4'h7, 21'h000000);
    check("push_noload", {23'h0, pc_load}, 24'h000000);
    rd_chk("push_ptr", 4'h0, 8'h01);
    op(4'h8, 21'h000000);
    check("pop_noload", {23'h0, pc_load}, 24'h000000);
    rd_chk("pop_ptr", 4'h0, 8'h00);
    op_r(4'h4, 21'h000000, 24'hA1B2C3);
    check("irq_high_pc", {3'h0, pc}, 24'h000008);
    op_r(4'h3, 21'h000000, 24'h112233);
    check("irq_low_pc", {3'h0, pc}, 24'h000018);
    rd_chk("irq_ptr", 4'h0, 8'h02);
    op_r(4'h6, 21'h000000, 24'h000000);
    check("fast_ret_load", {23'h0, regs_load}, 24'h000001);
    check("shadow_over", regs_out, 24'h112233);
    op_r(4'h2, 21'h000300, 24'h445566);
    op_r(4'h6, 21'h000000, 24'h000000);
    check("fast_call", regs_out, 24'h445566);
    wr_reg(4'h0, 8'h00);
    for (int i = 0; i < 31; i++)
      op(4'h1, 21'h000200);
    rd_chk("full_ptr", 4'h0, 8'h9F);
    wr_reg(4'h1, 8'h5A);
    op(4'h1, 21'h000200);
    rd_chk("full_hold_ptr", 4'h0, 8'h9F);
    rd_chk("full_hold_top", 4'h1, 8'h5A);
    wr_reg(4'h2, 8'hC3);
    wr_reg(4'h3, 8'hFF);
    rd_chk("top_high_wr", 4'h2, 8'hC3);
    rd_chk("top_upper_wr", 4'h3, 8'h1F);
    wr_reg(4'h4, 8'h01);
    wr_reg(4'h0, 8'h1E);
    op(4'h1, 21'h000200);
    check("ovf_reset", {23'h0, dev_reset}, 24'h000001);
    repeat (3) @(posedge mclk);
    rd_chk("ovf_ptr", 4'h0, 8'h80);
    @(posedge mclk);
    por <= 1'b1;
    @(posedge mclk);
    por <= 1'b0;
    rd_chk("por_clear", 4'h0, 8'h00);
    op(4'h8, 21'h000000);
    check("under_reset", {23'h0, dev_reset}, 24'h000001);
    rd_chk("under_rst_ptr", 4'h0, 8'h40);
    wr_reg(4'h0, 8'h07);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_chk("ptr_rereset", 4'h0, 8'h00);
    @(posedge mclk);
    fetch_addr <= 21'h004000;
    fetch_word <= 16'hFFFF;
    @(posedge mclk);
    #1;
    check("fetch_beyond", {8'h00, fword}, 24'h000000);
    @(posedge mclk);
    fetch_addr <= 21'h003FFE;
    @(posedge mclk);
    #1;
    check("fetch_inside", {8'h00, fword}, 24'h00FFFF);
    wrap_up();
  end
endmodule : ras_stack_test
